/* shared/pca_pwm_pkg.sv */
// constants for the counter array pwm configuration block
package pca_pwm_pkg;
  // register addresses on the sfr bus
  localparam logic [7:0] ADDR_PWM_CFG   = 8'hf7;
  localparam logic [7:0] ADDR_CLR_CTRL  = 8'h9c;
  localparam logic [7:0] ADDR_MODE0     = 8'hda;
  localparam logic [7:0] ADDR_MODE1     = 8'hdb;
  localparam logic [7:0] ADDR_MODE2     = 8'hdc;
  localparam logic [7:0] ADDR_CNT_LO    = 8'hf9;
  localparam logic [7:0] ADDR_CNT_HI    = 8'hfa;
  localparam logic [7:0] ADDR_CMP_LO0   = 8'hfb;
  localparam logic [7:0] ADDR_CMP_HI0   = 8'hfc;
  localparam logic [7:0] ADDR_CMP_LO1   = 8'he9;
  localparam logic [7:0] ADDR_CMP_HI1   = 8'hea;
  localparam logic [7:0] ADDR_CMP_LO2   = 8'heb;
  localparam logic [7:0] ADDR_CMP_HI2   = 8'hec;
  // pwm configuration fields
  localparam int BIT_RELOAD_SEL  = 7;
  localparam int BIT_COV_IRQ_EN  = 6;
  localparam int BIT_COV_FLAG    = 5;
  // comparator clear fields
  localparam int BIT_CLR_POL     = 7;
  // mode register fields
  localparam int BIT_WIDE_PWM    = 7;
  localparam int BIT_TOGGLE      = 2;
  localparam int BIT_PWM_EN      = 1;
  // reset values
  localparam logic [7:0] RST_PWM_CFG  = 8'h00;
  localparam logic [7:0] RST_CLR_CTRL = 8'h00;
  localparam logic [7:0] RST_MODE     = 8'h00;
  localparam logic [15:0] RST_WORD    = 16'h0000;
  // writable bit masks, reserved bits read zero; cycle length select codes
  localparam logic [7:0] MASK_PWM_CFG  = 8'he7;
  localparam logic [7:0] MASK_CLR_CTRL = 8'h87;
  localparam logic [2:0] CYCLE_LENGTH_SELECT_8BIT    = 3'h0;
  localparam logic [2:0] CYCLE_LENGTH_SELECT_11BIT   = 3'h3;
endpackage

/* rtl/counter_array_pwm_config.sv */
// pwm configuration, cycle overflow and comparator clear for a three channel counter array
// Function
// [R1] reload access select steers compare addresses to compare or reload values
// [R2] reload values set the compare value used in 9 to 11 bit pwm
// [R3] reload values do nothing outside 9 to 11 bit pwm
// [R4] overflow irq enable gates the overflow flag onto the shared interrupt
// [R5] overflow flag sets on counter overflow at selected bit 8 to 11
// [R6] overflow flag set by hardware or software write 1, cleared only by software
// [R7] length select 000..011 gives 8..11 bits, 100..111 reserved
// [R8] cycle length applies to every non 16 bit pwm channel
// [R9] 16 bit pwm channels ignore the shared cycle length
// [R10] software writes reserved bits with their reset value
// [R11] clear polarity picks falling (0) or rising (1) comparator edge
// [R12] three enable bits allow comparator clear on channels 0, 1, 2
// [R13] each channel has an 8 bit mode register, reset to zero
// [R14] per channel wide select picks 16 bit or shared length pwm
// [R15] pwm enable drives pwm on the pin; with toggle, frequency output
// [R16] main counter is 16 bits, read and written as two bytes
// [R17] reload value copies into compare value at each cycle overflow; the code copies only on 9 to 11 bit pwm channels
// [R18] qualifying comparator edge holds enabled outputs low until next cycle
`timescale 1ns/1ns
`default_nettype none
module counter_array_pwm_config #(
  parameter int CHANNELS = 3
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic [7:0]          sfrAddr,
  input  wire logic [7:0]          sfrWdata,
  input  wire logic                sfrWrite,
  input  wire logic                sfrRead,
  output logic      [7:0]          sfrRdata,
  input  wire logic                counterTick,
  input  wire logic                comparatorIn,
  output logic      [CHANNELS-1:0] channelOut,
  output logic                     counterArrayIrq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  pwmCfg;
  logic [7:0]  clrCtrl;
  logic [7:0]  mode [CHANNELS];
  logic [15:0] compareValue [CHANNELS];
  logic [15:0] reloadValue [CHANNELS];
  logic [15:0] mainCounter;
  logic [CHANNELS-1:0] clearHold;
  logic        cmpSync1;
  logic        cmpSync2;
  logic        cmpPrev;
  logic [15:0] next_counter;
  logic        cycleWrap;
  logic        cmpEdge;
  logic [10:0] cycleMask;

  function automatic logic [7:0] cmpLoAddr(input int ch);
    case (ch)
      0:       return pca_pwm_pkg::ADDR_CMP_LO0;
      1:       return pca_pwm_pkg::ADDR_CMP_LO1;
      default: return pca_pwm_pkg::ADDR_CMP_LO2;
    endcase
  endfunction

  function automatic logic [7:0] cmpHiAddr(input int ch);
    case (ch)
      0:       return pca_pwm_pkg::ADDR_CMP_HI0;
      1:       return pca_pwm_pkg::ADDR_CMP_HI1;
      default: return pca_pwm_pkg::ADDR_CMP_HI2;
    endcase
  endfunction

  function automatic logic [7:0] modeAddr(input int ch);
    case (ch)
      0:       return pca_pwm_pkg::ADDR_MODE0;
      1:       return pca_pwm_pkg::ADDR_MODE1;
      default: return pca_pwm_pkg::ADDR_MODE2;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // cycle length and wrap detect
  always_comb begin
    unique case (pwmCfg[2:0])
      3'h1:    cycleMask = 11'h1ff; // R7
      3'h2:    cycleMask = 11'h3ff; // R7
      3'h3:    cycleMask = 11'h7ff; // R7
      default: cycleMask = 11'h0ff; // R7
    endcase
  end

  assign next_counter = mainCounter + 16'h0001;
  // overflow out of the selected bit: all lower bits of the cycle were ones
  assign cycleWrap = counterTick && ((mainCounter[10:0] & cycleMask) == cycleMask); // R5

  ////////////////////////////////////////////////////////////////////////////
  // comparator input synchroniser and edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmpSync1 <= 1'b0;
      cmpSync2 <= 1'b0;
      cmpPrev  <= 1'b0;
    end else begin
      cmpSync1 <= comparatorIn;
      cmpSync2 <= cmpSync1;
      cmpPrev  <= cmpSync2;
    end
  end

  assign cmpEdge = clrCtrl[pca_pwm_pkg::BIT_CLR_POL] ? (cmpSync2 && !cmpPrev)
                                                     : (!cmpSync2 && cmpPrev); // R11

  ////////////////////////////////////////////////////////////////////////////
  // main counter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mainCounter <= pca_pwm_pkg::RST_WORD;
    end else if (sfrWrite && sfrAddr == pca_pwm_pkg::ADDR_CNT_LO) begin
      mainCounter[7:0] <= sfrWdata; // R16
    end else if (sfrWrite && sfrAddr == pca_pwm_pkg::ADDR_CNT_HI) begin
      mainCounter[15:8] <= sfrWdata; // R16
    end else if (counterTick) begin
      mainCounter <= next_counter;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pwmCfg <= pca_pwm_pkg::RST_PWM_CFG;
    end else begin
      if (sfrWrite && sfrAddr == pca_pwm_pkg::ADDR_PWM_CFG) begin
        pwmCfg <= sfrWdata & pca_pwm_pkg::MASK_PWM_CFG; // R10
      end
      // hardware set wins over a software clear
      if (cycleWrap) begin
        pwmCfg[pca_pwm_pkg::BIT_COV_FLAG] <= 1'b1; // R5 R6
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clrCtrl <= pca_pwm_pkg::RST_CLR_CTRL;
    end else if (sfrWrite && sfrAddr == pca_pwm_pkg::ADDR_CLR_CTRL) begin
      clrCtrl <= sfrWdata & pca_pwm_pkg::MASK_CLR_CTRL; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per channel mode, compare, reload and output
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
    logic wide;
    logic pwmOn;
    logic shortPwm;
    logic wrapHere;
    logic [15:0] cntView;
    logic [15:0] cmpView;
    assign wide     = mode[ch][pca_pwm_pkg::BIT_WIDE_PWM];
    assign pwmOn    = mode[ch][pca_pwm_pkg::BIT_PWM_EN] && !mode[ch][pca_pwm_pkg::BIT_TOGGLE];
    assign shortPwm = pwmOn && !wide; // R14
    // 16 bit channels use the full counter, others the shared length
    assign wrapHere = wide ? (counterTick && mainCounter == 16'hffff) : cycleWrap; // R8 R9
    assign cntView  = wide ? mainCounter : {5'h00, mainCounter[10:0] & cycleMask}; // R9
    assign cmpView  = wide ? compareValue[ch] : {5'h00, compareValue[ch][10:0] & cycleMask};

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        mode[ch] <= pca_pwm_pkg::RST_MODE; // R13
      end else if (sfrWrite && sfrAddr == modeAddr(ch)) begin
        mode[ch] <= sfrWdata; // R13
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        compareValue[ch] <= pca_pwm_pkg::RST_WORD;
        reloadValue[ch]  <= pca_pwm_pkg::RST_WORD;
      end else begin
        if (sfrWrite && sfrAddr == cmpLoAddr(ch)) begin
          if (pwmCfg[pca_pwm_pkg::BIT_RELOAD_SEL]) begin
            reloadValue[ch][7:0] <= sfrWdata; // R1
          end else begin
            compareValue[ch][7:0] <= sfrWdata; // R1
          end
        end else if (sfrWrite && sfrAddr == cmpHiAddr(ch)) begin
          if (pwmCfg[pca_pwm_pkg::BIT_RELOAD_SEL]) begin
            reloadValue[ch][15:8] <= sfrWdata; // R1
          end else begin
            compareValue[ch][15:8] <= sfrWdata; // R1
          end
        end else if (shortPwm && cycleWrap && pwmCfg[2:0] != pca_pwm_pkg::CYCLE_LENGTH_SELECT_8BIT
                     && pwmCfg[2] == 1'b0) begin
          compareValue[ch] <= reloadValue[ch]; // R2 R3 R17
        end
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        clearHold[ch] <= 1'b0;
      end else if (cmpEdge && clrCtrl[ch]) begin
        clearHold[ch] <= 1'b1; // R12 R18
      end else if (wrapHere) begin
        clearHold[ch] <= 1'b0; // R18
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        channelOut[ch] <= 1'b0;
      end else if (mode[ch][pca_pwm_pkg::BIT_PWM_EN] && mode[ch][pca_pwm_pkg::BIT_TOGGLE]) begin
        if (counterTick && mainCounter == compareValue[ch]) begin
          channelOut[ch] <= !channelOut[ch]; // R15
        end
      end else if (pwmOn) begin
        channelOut[ch] <= !(clearHold[ch] || (cmpEdge && clrCtrl[ch]))
                          && (cntView < cmpView); // R15 R18
      end else begin
        channelOut[ch] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and read data
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      counterArrayIrq <= 1'b0;
    end else begin
      counterArrayIrq <= pwmCfg[pca_pwm_pkg::BIT_COV_IRQ_EN]
                         && pwmCfg[pca_pwm_pkg::BIT_COV_FLAG]; // R4
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sfrRdata <= 8'h00;
    end else if (sfrRead) begin
      sfrRdata <= 8'h00;
      if (sfrAddr == pca_pwm_pkg::ADDR_PWM_CFG) sfrRdata <= pwmCfg;
      if (sfrAddr == pca_pwm_pkg::ADDR_CLR_CTRL) sfrRdata <= clrCtrl;
      if (sfrAddr == pca_pwm_pkg::ADDR_CNT_LO) sfrRdata <= mainCounter[7:0];
      if (sfrAddr == pca_pwm_pkg::ADDR_CNT_HI) sfrRdata <= mainCounter[15:8];
      for (int ch = 0; ch < CHANNELS; ch++) begin
        if (sfrAddr == modeAddr(ch)) sfrRdata <= mode[ch];
        if (sfrAddr == cmpLoAddr(ch)) begin
          sfrRdata <= pwmCfg[pca_pwm_pkg::BIT_RELOAD_SEL] ? reloadValue[ch][7:0]
                                                          : compareValue[ch][7:0]; // R1
        end
        if (sfrAddr == cmpHiAddr(ch)) begin
          sfrRdata <= pwmCfg[pca_pwm_pkg::BIT_RELOAD_SEL] ? reloadValue[ch][15:8]
                                                          : compareValue[ch][15:8]; // R1
        end
      end
    end
  end
endmodule
`default_nettype wire

/* verification/counter_array_pwm_config_properties.sv */
// assertions on the ports of the counter array pwm configuration block
`timescale 1ns/1ns
`default_nettype none
module counter_array_pwm_config_properties #(
  parameter int CHANNELS = 3
) (
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire logic [7:0]          sfrAddr,
  input wire logic [7:0]          sfrWdata,
  input wire logic                sfrWrite,
  input wire logic                sfrRead,
  input wire logic [7:0]          sfrRdata,
  input wire logic                counterTick,
  input wire logic                comparatorIn,
  input wire logic [CHANNELS-1:0] channelOut,
  input wire logic                counterArrayIrq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic wCfg;
  assign wCfg = sfrWrite && sfrAddr == pca_pwm_pkg::ADDR_PWM_CFG;
  ////////////////////////////////////////////////////////////////////////////
  a_reset_outputs_low: assert property (disable iff (1'b0)
    !rst_n |=> channelOut == '0 && !counterArrayIrq && sfrRdata == 8'h00)
    else $error("outputs not low after reset");
  a_unmapped_reads_zero: assert property (
    sfrRead && sfrAddr == 8'h00 |=> sfrRdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!sfrRead |=> $stable(sfrRdata))
    else $error("read data changed without read");
  a_irq_off_disabled: assert property (
    wCfg && !sfrWdata[6] ##1 !wCfg |=> !counterArrayIrq) else $error("irq with enable off");
  a_irq_on_set: assert property (
    wCfg && sfrWdata[6] && sfrWdata[5] ##1 !wCfg |=> counterArrayIrq)
    else $error("irq missing after flag set");
  a_cfg_readback: assert property (
    wCfg ##1 (sfrRead && sfrAddr == pca_pwm_pkg::ADDR_PWM_CFG) |=> (sfrRdata & 8'hdf)
    == ($past(sfrWdata, 2) & pca_pwm_pkg::MASK_PWM_CFG & 8'hdf)) else $error("cfg readback");
  a_clr_readback: assert property (
    sfrWrite && sfrAddr == pca_pwm_pkg::ADDR_CLR_CTRL ##1
    (sfrRead && sfrAddr == pca_pwm_pkg::ADDR_CLR_CTRL) |=>
    sfrRdata == ($past(sfrWdata, 2) & pca_pwm_pkg::MASK_CLR_CTRL)) else $error("clr readback");
  a_mode_readback: assert property (
    sfrWrite && sfrAddr == pca_pwm_pkg::ADDR_MODE0 ##1
    (sfrRead && sfrAddr == pca_pwm_pkg::ADDR_MODE0) |=> sfrRdata == $past(sfrWdata, 2))
    else $error("mode readback");
  c_cfg_write: cover property (wCfg);
  c_irq_rise: cover property ($rose(counterArrayIrq));
  c_out_fall: cover property ($fell(channelOut[0]));
endmodule
`default_nettype wire

/* verification/test_counter_array_pwm_config.sv */
// self-checking bench for the counter array pwm configuration block
`timescale 1ns/1ns
`default_nettype none
module test_counter_array_pwm_config;
  logic       clk_sys = 1'b0, rst_n = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0;
  logic       counterTick = 1'b0, comparatorIn = 1'b1, counterArrayIrq;
  logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
  logic [2:0] channelOut;
  int         failures = 0, checks = 0, cycles = 0;
  counter_array_pwm_config u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfrAddr(sfrAddr),
    .sfrWdata(sfrWdata), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrRdata(sfrRdata),
    .counterTick(counterTick), .comparatorIn(comparatorIn), .channelOut(channelOut),
    .counterArrayIrq(counterArrayIrq));
  initial forever #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk_sys);
    sfrAddr = a;
    sfrWdata = d;
    sfrWrite = 1'b1;
    @(negedge clk_sys);
    sfrWrite = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, string n);
    @(negedge clk_sys);
    sfrAddr = a;
    sfrRead = 1'b1;
    @(negedge clk_sys);
    sfrRead = 1'b0;
    chk(n, e, sfrRdata);
  endtask
  task automatic tick();
    @(negedge clk_sys);
    counterTick = 1'b1;
    @(negedge clk_sys);
    counterTick = 1'b0;
  endtask
  task automatic wait_chk(int n, logic e, string s);
    repeat (n) @(negedge clk_sys);
    chk(s, {7'h00, e}, {7'h00, channelOut[0]});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(pca_pwm_pkg::ADDR_PWM_CFG, 8'h00, "cfg reset");
    wr(pca_pwm_pkg::ADDR_PWM_CFG, 8'he7);
    rd(pca_pwm_pkg::ADDR_PWM_CFG, 8'he7, "cfg");
    chk("irq", 8'h01, {7'h00, counterArrayIrq});
    wr(pca_pwm_pkg::ADDR_PWM_CFG, 8'h20);
    @(negedge clk_sys);
    chk("irq masked", 8'h00, {7'h00, counterArrayIrq});
    wr(pca_pwm_pkg::ADDR_PWM_CFG, 8'h00);
    rd(pca_pwm_pkg::ADDR_PWM_CFG, 8'h00, "flag clear");
    wr(pca_pwm_pkg::ADDR_CLR_CTRL, 8'h87);
    rd(pca_pwm_pkg::ADDR_CLR_CTRL, 8'h87, "clr");
    wr(pca_pwm_pkg::ADDR_MODE0, 8'hff);
    rd(pca_pwm_pkg::ADDR_MODE0, 8'hff, "mode0");
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00, "unmapped");
    wr(pca_pwm_pkg::ADDR_MODE0, 8'h00);
    // back to back write then read of the configuration
    @(negedge clk_sys);
    sfrAddr = pca_pwm_pkg::ADDR_PWM_CFG;
    sfrWdata = 8'h43;
    sfrWrite = 1'b1;
    @(negedge clk_sys);
    sfrWrite = 1'b0;
    sfrRead = 1'b1;
    @(negedge clk_sys);
    sfrRead = 1'b0;
    chk("cfg back to back", 8'h43, sfrRdata);
  endtask
  task automatic t_overflow();
    for (int k = 0; k < 4; k++) begin
      wr(pca_pwm_pkg::ADDR_PWM_CFG, 8'(k));
      wr(pca_pwm_pkg::ADDR_CNT_LO, 8'hff);
      if (k > 0) begin
        wr(pca_pwm_pkg::ADDR_CNT_HI, 8'((1 << (k - 1)) - 1));
        tick();
        rd(pca_pwm_pkg::ADDR_PWM_CFG, 8'(k), "no overflow");
        wr(pca_pwm_pkg::ADDR_CNT_LO, 8'hff);
      end
      wr(pca_pwm_pkg::ADDR_CNT_HI, 8'((1 << k) - 1));
      tick();
      rd(pca_pwm_pkg::ADDR_PWM_CFG, 8'h20 | 8'(k), "overflow");
      rd(pca_pwm_pkg::ADDR_CNT_LO, 8'h00, "count lo");
      rd(pca_pwm_pkg::ADDR_CNT_HI, 8'(1 << k), "count hi");
    end
    wr(pca_pwm_pkg::ADDR_PWM_CFG, 8'h00);
  endtask
  task automatic t_reload();
    wr(pca_pwm_pkg::ADDR_PWM_CFG, 8'h80);
    wr(pca_pwm_pkg::ADDR_CMP_LO0, 8'h55);
    wr(pca_pwm_pkg::ADDR_PWM_CFG, 8'h00);
    wr(pca_pwm_pkg::ADDR_CMP_LO0, 8'h22);
    rd(pca_pwm_pkg::ADDR_CMP_LO0, 8'h22, "compare");
    wr(pca_pwm_pkg::ADDR_PWM_CFG, 8'h80);
    rd(pca_pwm_pkg::ADDR_CMP_LO0, 8'h55, "reload");
    wr(pca_pwm_pkg::ADDR_PWM_CFG, 8'h00);
  endtask
  task automatic t_clear();
    wr(pca_pwm_pkg::ADDR_CMP_LO0, 8'h80);
    wr(pca_pwm_pkg::ADDR_CMP_HI0, 8'h80);
    wr(pca_pwm_pkg::ADDR_CNT_LO, 8'h00);
    wr(pca_pwm_pkg::ADDR_CNT_HI, 8'h00);
    wr(pca_pwm_pkg::ADDR_MODE0, 8'h02);
    wr(pca_pwm_pkg::ADDR_CLR_CTRL, 8'h01);
    wait_chk(4, 1'b1, "pwm high");
    comparatorIn = 1'b0;
    wait_chk(6, 1'b0, "cleared on fall");
    wr(pca_pwm_pkg::ADDR_CNT_LO, 8'hff);
    tick();
    wait_chk(3, 1'b1, "released at wrap");
    wr(pca_pwm_pkg::ADDR_CLR_CTRL, 8'h82);
    comparatorIn = 1'b1;
    wait_chk(6, 1'b1, "channel not enabled");
    wr(pca_pwm_pkg::ADDR_CLR_CTRL, 8'h81);
    comparatorIn = 1'b0;
    wait_chk(6, 1'b1, "fall ignored");
    comparatorIn = 1'b1;
    wait_chk(6, 1'b0, "cleared on rise");
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    t_regs();
    t_overflow();
    t_reload();
    t_clear();
    stop_test();
  end
endmodule
bind counter_array_pwm_config counter_array_pwm_config_properties #(.CHANNELS(CHANNELS))
  u_props (.clk_sys(clk_sys), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
  .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrRdata(sfrRdata), .counterTick(counterTick),
  .comparatorIn(comparatorIn), .channelOut(channelOut), .counterArrayIrq(counterArrayIrq));
`default_nettype wire
